// File: design/emu_run_pkg.sv
// Package: register map, field positions, reset values and codes for the emulator run control.
// Assumes a 32-bit APB slave with word-aligned registers.
package emu_run_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] CMD_OFF      = 8'h04;
  localparam logic [7:0] STATUS_OFF   = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h10;
  localparam logic [7:0] CS_OFF       = 8'h14;
  localparam logic [7:0] IP_OFF       = 8'h18;
  localparam logic [7:0] FLAGS_OFF    = 8'h1C;
  localparam logic [7:0] CNT_OFF      = 8'h20;
  localparam logic [7:0] CMP0_OFF     = 8'h24;
  localparam logic [7:0] CMP1_OFF     = 8'h28;
  localparam logic [7:0] CMP2_OFF     = 8'h2C;
  localparam logic [7:0] CMP3_OFF     = 8'h30;
  localparam logic [7:0] GROUP_OFF    = 8'h34;

  // Control register fields
  localparam int CTRL_RDY_BIT = 0;

  // Command codes written to CMD (low 3 bits)
  localparam logic [2:0] CMD_RUN       = 3'h1;
  localparam logic [2:0] CMD_RUN_BRK   = 3'h2;
  localparam logic [2:0] CMD_VRUN      = 3'h3;
  localparam logic [2:0] CMD_VRUN_BRK  = 3'h4;
  localparam logic [2:0] CMD_RESET     = 3'h5;
  localparam logic [2:0] CMD_LOADVEC   = 3'h6;
  localparam logic [2:0] CMD_STOP      = 3'h7;

  // Interrupt status bit positions
  localparam int IRQ_BREAK_BIT  = 0;
  localparam int IRQ_REJECT_BIT = 1;
  localparam int IRQ_RELOAD_BIT = 2;
  localparam int IRQ_WIDTH      = 3;

  // Reset vector values
  localparam logic [15:0] RESET_CS    = 16'hFFFF;
  localparam logic [15:0] RESET_IP    = 16'h0000;
  localparam logic [15:0] RESET_FLAGS = 16'hF002;

  // Pod reset pulse length in clocks
  localparam int POD_RST_CYCLES = 4;

  // Run state
  typedef enum logic [0:0] {
    PAUSE = 1'b0,
    RUN   = 1'b1
  } run_state_t;

endpackage

// File: design/emulator_run_control.sv
// Run control, ready selection and hardware event counter of an emulator pod.
// Assumes an APB master on clk, and target/pod signals synchronous to clk.
//
// Operation
// - Trigger with reload action copies group count comparator into counter.
// - Group switch keeps counter value unless reload listed for same events.
// - Ready switch on: own ready ends memory cycles without a target.
// - Ready switch off: cycles end only on target ready.
// - Ready source change accepted only while paused, rejected in run.
// - With internal ready on, first of internal or target ready wins.
// - Internal ready is not synchronised to target readiness.
// - Ready source defaults to target, internal if no target clock and internal clock strap at power-up.
// - Reset command resets pod and loads CS FFFF, IP 0, flags F002.
// - Reset during run resets pod in target and stops emulation.
// - Reset command never asserts the target reset signal.
// - Reset command and reset character stop run; character leaves image alone.
// - Four run variants: current or reloaded vectors, breaks on or off.
// - Vector-loading run variants accepted only in pause.
// - Breakpoint-enabled runs keep every defined event trigger active.
// - Vector run equals load vectors then matching current-location run.
`timescale 1ns/10ps
module emulator_run_control #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Power-up straps
  input  wire logic             targetClockSeen,
  input  wire logic             internalClockSel,
  // Host reset character
  input  wire logic             resetChar,
  // Event system
  input  wire logic             triggerHit,
  input  wire logic             counterReloadAction,
  input  wire logic             groupSwitchAction,
  input  wire logic [1:0]       groupSwitchTarget,
  input  wire logic             countIncrementAction,
  input  wire logic             breakAction,
  // Pod bus cycle
  input  wire logic             cycleRequest,
  input  wire logic             targetReady,
  output logic                  cycleReady,
  // Pod and target control
  output logic                  podReset,
  output logic                  targetReset,
  output logic                  eventsArmed,
  output logic                  countLimit,
  output logic                  irq
);

  emu_run_pkg::run_state_t runState;
  emu_run_pkg::run_state_t next_runState;

  logic             readySel;
  logic             strapDone;
  logic [15:0]      csImage;
  logic [15:0]      ipImage;
  logic [15:0]      flagsImage;
  logic [CNT_W-1:0] hwCounter;
  logic [CNT_W-1:0] cmpValue [4];
  logic [1:0]       activeGroup;
  logic             breaksOn;
  logic [2:0]       podRstCnt;
  logic [emu_run_pkg::IRQ_WIDTH-1:0] irqStat;
  logic [emu_run_pkg::IRQ_WIDTH-1:0] irqMask;

  // APB decode
  wire        wrEn     = psel & penable & pwrite;
  wire        rdEn     = psel & ~penable & ~pwrite;
  wire        cmdWr    = wrEn && paddr == emu_run_pkg::CMD_OFF;
  wire [2:0]  cmdCode  = pwdata[2:0];
  wire        isPause  = runState == emu_run_pkg::PAUSE;
  wire        isVecRun = cmdCode == emu_run_pkg::CMD_VRUN || cmdCode == emu_run_pkg::CMD_VRUN_BRK;
  wire        isRun    = cmdCode == emu_run_pkg::CMD_RUN || cmdCode == emu_run_pkg::CMD_RUN_BRK;
  wire        vecRunOk = cmdWr && isVecRun && isPause;
  wire        runOk    = cmdWr && isRun;
  wire        cmdReset = cmdWr && cmdCode == emu_run_pkg::CMD_RESET;
  wire        loadVec  = vecRunOk || cmdReset ||
                         (cmdWr && cmdCode == emu_run_pkg::CMD_LOADVEC && isPause);
  wire        stopReq  = cmdWr && cmdCode == emu_run_pkg::CMD_STOP;
  wire        ctrlWr   = wrEn && paddr == emu_run_pkg::CTRL_OFF;
  wire        rdySelOk = ctrlWr && isPause;
  wire        rejected = (ctrlWr && !isPause) || (cmdWr && isVecRun && !isPause) ||
                         (cmdWr && cmdCode == emu_run_pkg::CMD_LOADVEC && !isPause);
  wire        brkHit   = triggerHit && breakAction && breaksOn && !isPause;
  wire        cmpWr    = wrEn && paddr >= emu_run_pkg::CMP0_OFF && paddr <= emu_run_pkg::CMP3_OFF;
  wire [1:0]  cmpIdx   = 2'((paddr - emu_run_pkg::CMP0_OFF) >> 2);
  wire [1:0]  newGroup = groupSwitchAction ? groupSwitchTarget : activeGroup;
  wire        reloadEv = triggerHit && counterReloadAction;
  wire [emu_run_pkg::IRQ_WIDTH-1:0] irqEv = {reloadEv, rejected, brkHit};

  // Read mux
  logic [31:0] rdData;
  always_comb begin
    unique case (paddr)
      emu_run_pkg::CTRL_OFF:     rdData = {31'h0000_0000, readySel};
      emu_run_pkg::STATUS_OFF:   rdData = {29'h0000_0000, breaksOn, podReset, runState};
      emu_run_pkg::IRQ_STAT_OFF: rdData = {29'h0000_0000, irqStat};
      emu_run_pkg::IRQ_MASK_OFF: rdData = {29'h0000_0000, irqMask};
      emu_run_pkg::CS_OFF:       rdData = {16'h0000, csImage};
      emu_run_pkg::IP_OFF:       rdData = {16'h0000, ipImage};
      emu_run_pkg::FLAGS_OFF:    rdData = {16'h0000, flagsImage};
      emu_run_pkg::CNT_OFF:      rdData = 32'(hwCounter);
      emu_run_pkg::CMP0_OFF:     rdData = 32'(cmpValue[0]);
      emu_run_pkg::CMP1_OFF:     rdData = 32'(cmpValue[1]);
      emu_run_pkg::CMP2_OFF:     rdData = 32'(cmpValue[2]);
      emu_run_pkg::CMP3_OFF:     rdData = 32'(cmpValue[3]);
      emu_run_pkg::GROUP_OFF:    rdData = {30'h0000_0000, activeGroup};
      default:                   rdData = 32'h0000_0000;
    endcase
  end

  wire knownAddr = paddr <= emu_run_pkg::GROUP_OFF && paddr[1:0] == 2'b00;

  // APB answer, registered in setup, ready in first access cycle with no wait state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (rdEn) prdata <= rdData;
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~knownAddr;
    end
  end

  // Run state next value
  // state changes on run, break, stop, reset command or reset character
  always_comb begin
    next_runState = runState;
    unique case (runState)
      emu_run_pkg::PAUSE: if (runOk || vecRunOk) next_runState = emu_run_pkg::RUN;
      emu_run_pkg::RUN:   if (brkHit || stopReq || cmdReset || resetChar) next_runState = emu_run_pkg::PAUSE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) runState <= emu_run_pkg::PAUSE;
    else         runState <= next_runState;
  end

  // Break enable follows the chosen run variant
  // four run variants
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      breaksOn <= 1'b0;
    end else if (runOk || vecRunOk) begin
      breaksOn <= cmdCode == emu_run_pkg::CMD_RUN_BRK || cmdCode == emu_run_pkg::CMD_VRUN_BRK;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) eventsArmed <= 1'b0;
    else         eventsArmed <= (next_runState == emu_run_pkg::RUN) && (breaksOn || runOk || vecRunOk) &&
                                !(runOk || vecRunOk) || ((runOk || vecRunOk) &&
                                (cmdCode == emu_run_pkg::CMD_RUN_BRK || cmdCode == emu_run_pkg::CMD_VRUN_BRK));
  end

  // Ready source, strap caught after reset release
  // power-up default
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readySel  <= 1'b0;
      strapDone <= 1'b0;
    end else if (!strapDone) begin
      readySel  <= !targetClockSeen && internalClockSel;
      strapDone <= 1'b1;
    end else if (rdySelOk) begin
      readySel  <= pwdata[emu_run_pkg::CTRL_RDY_BIT];
    end
  end

  // Cycle end: internal ready unsynchronised, else target ready
  // ready select
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cycleReady <= 1'b0;
    else         cycleReady <= cycleRequest && (readySel || targetReady);
  end

  // Register image, vector load and pause writes
  // reset loads vectors
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      csImage    <= emu_run_pkg::RESET_CS;
      ipImage    <= emu_run_pkg::RESET_IP;
      flagsImage <= emu_run_pkg::RESET_FLAGS;
    end else if (loadVec) begin
      csImage    <= emu_run_pkg::RESET_CS;
      ipImage    <= emu_run_pkg::RESET_IP;
      flagsImage <= emu_run_pkg::RESET_FLAGS;
    end else if (wrEn && isPause) begin
      if (paddr == emu_run_pkg::CS_OFF)    csImage    <= pwdata[15:0];
      if (paddr == emu_run_pkg::IP_OFF)    ipImage    <= pwdata[15:0];
      if (paddr == emu_run_pkg::FLAGS_OFF) flagsImage <= pwdata[15:0];
    end
  end

  // Pod reset pulse from command or reset character
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      podRstCnt <= 3'h0;
      podReset  <= 1'b0;
    end else begin
      if (cmdReset || resetChar) podRstCnt <= 3'(emu_run_pkg::POD_RST_CYCLES);
      else if (podRstCnt != 3'h0) podRstCnt <= podRstCnt - 3'h1;
      podReset <= cmdReset || resetChar || podRstCnt > 3'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) targetReset <= 1'b0;
    else         targetReset <= 1'b0;
  end

  // Comparators per group
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) cmpValue[i] <= '0;
    end else if (cmpWr) begin
      cmpValue[cmpIdx] <= pwdata[CNT_W-1:0];
    end
  end

  // Hardware counter and active group
  // reload from comparator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hwCounter   <= '0;
      activeGroup <= 2'h0;
      countLimit  <= 1'b0;
    end else begin
      if (triggerHit) activeGroup <= newGroup;
      if (reloadEv) hwCounter <= cmpValue[newGroup];
      else if (triggerHit && countIncrementAction) hwCounter <= hwCounter + 1'b1;
      else if (wrEn && paddr == emu_run_pkg::CNT_OFF) hwCounter <= pwdata[CNT_W-1:0];
      countLimit <= hwCounter == cmpValue[activeGroup];
    end
  end

  // Interrupt status, set wins over write-one clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStat <= '0;
      irqMask <= '0;
      irq     <= 1'b0;
    end else begin
      if (wrEn && paddr == emu_run_pkg::IRQ_MASK_OFF) irqMask <= pwdata[emu_run_pkg::IRQ_WIDTH-1:0];
      if (wrEn && paddr == emu_run_pkg::IRQ_STAT_OFF)
        irqStat <= (irqStat & ~pwdata[emu_run_pkg::IRQ_WIDTH-1:0]) | irqEv;
      else
        irqStat <= irqStat | irqEv;
      irq <= |(irqStat & irqMask);
    end
  end

endmodule // emulator_run_control

// File: test/emu_run_checker_assertions.sv
// Checker: port assertions for the run control block.
// Assumes it is bound into emulator_run_control.
`timescale 1ns/10ps
module emu_run_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // Events and pod cycles
  input wire logic resetChar,
  input wire logic triggerHit,
  input wire logic breakAction,
  input wire logic cycleRequest,
  input wire logic targetReady,
  input wire logic cycleReady,
  // Pod and target control
  input wire logic podReset,
  input wire logic targetReset,
  input wire logic eventsArmed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pulse and setup shapes
  sequence s_podPulse; podReset [*4] ##1 !podReset; endsequence
  sequence s_setup; psel && !penable; endsequence
  // Properties
  property p_tgtRst; !targetReset; endproperty
  property p_podPulse; $rose(podReset) |-> s_podPulse; endproperty
  property p_charStop; resetChar |-> ##[1:5] (podReset && !eventsArmed); endproperty
  property p_zeroWait; s_setup |=> pready; endproperty
  property p_errRdy; pslverr |-> pready; endproperty
  property p_firstRdy; cycleRequest && targetReady |=> cycleReady; endproperty
  property p_rdyCause; cycleReady |-> $past(cycleRequest); endproperty
  property p_brkStop; triggerHit && breakAction && eventsArmed |=> !eventsArmed; endproperty
  property p_armCause; $rose(eventsArmed) |-> $past(psel && penable && pwrite); endproperty
  a_tgtRst: assert property (p_tgtRst) else $error("target reset driven");
  a_podPulse: assert property (p_podPulse) else $error("pod reset width");
  a_charStop: assert property (p_charStop) else $error("reset char no stop");
  a_zeroWait: assert property (p_zeroWait) else $error("no ready in access");
  a_errRdy: assert property (p_errRdy) else $error("error without ready");
  a_firstRdy: assert property (p_firstRdy) else $error("target ready ignored");
  a_rdyCause: assert property (p_rdyCause) else $error("ready without cycle");
  a_brkStop: assert property (p_brkStop) else $error("break kept running");
  a_armCause: assert property (p_armCause) else $error("run without command");
endmodule // emu_run_checker
bind emulator_run_control emu_run_checker u_chk (.clk, .sys_rst, .psel, .penable, .pwrite, .pready,
  .pslverr, .resetChar, .triggerHit, .breakAction, .cycleRequest, .targetReady, .cycleReady,
  .podReset, .targetReset, .eventsArmed);

// File: test/target_model.sv
// Target system model: answers pod memory cycles with ready.
// Assumes the pod holds cycleRequest until its cycle ends.
`timescale 1ns/10ps
module target_model (
  // Clock
  input  wire logic clk,
  // Pod cycle and speed
  input  wire logic cycleRequest,
  input  wire logic slowMode,
  output logic      targetReady
);
  logic [1:0] waitCnt;
  // Ready at once, or after two wait clocks
  always_ff @(posedge clk) begin
    if (!cycleRequest) begin
      waitCnt     <= 2'h0;
      targetReady <= 1'b0;
    end else begin
      waitCnt     <= waitCnt + 2'h1;
      targetReady <= !slowMode || (waitCnt == 2'h2);
    end
  end
endmodule // target_model

// File: test/emulator_run_control_bench.sv
// Bench: register table, events, ready and reset cases.
// Assumes target_model and the bound checker are compiled.
`timescale 1ns/10ps
module emulator_run_control_bench;
  typedef struct packed {logic wr; logic [7:0] adr; logic [31:0] dat;} row_t;
  logic        clk, sys_rst, psel, penable, pwrite, slowMode, resetChar, triggerHit;
  logic        counterReloadAction, groupSwitchAction, breakAction, cycleRequest, er;
  logic [1:0]  groupSwitchTarget;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, targetReady, cycleReady, podReset, targetReset;
  logic        eventsArmed, countLimit, irq, strapTgtClk, strapIntClk;
  int          nFail, checked, n;
  // Register cases: write data or expected read data
  localparam row_t ROWS [15] = '{
    '{1'b0, emu_run_pkg::CTRL_OFF, 32'h0000_0000},
    '{1'b1, emu_run_pkg::CMD_OFF, 32'(emu_run_pkg::CMD_RESET)},
    '{1'b0, emu_run_pkg::CS_OFF, 32'h0000_FFFF},
    '{1'b0, emu_run_pkg::IP_OFF, 32'h0000_0000},
    '{1'b0, emu_run_pkg::FLAGS_OFF, 32'h0000_F002},
    '{1'b1, emu_run_pkg::CTRL_OFF, 32'h0000_0001},
    '{1'b1, emu_run_pkg::CMD_OFF, 32'(emu_run_pkg::CMD_RUN_BRK)},
    '{1'b0, emu_run_pkg::STATUS_OFF, 32'h0000_0005},
    '{1'b1, emu_run_pkg::CTRL_OFF, 32'h0000_0000},
    '{1'b0, emu_run_pkg::CTRL_OFF, 32'h0000_0001},
    '{1'b1, emu_run_pkg::IRQ_STAT_OFF, 32'h0000_0002},
    '{1'b1, emu_run_pkg::CMD_OFF, 32'(emu_run_pkg::CMD_VRUN)},
    '{1'b0, emu_run_pkg::IRQ_STAT_OFF, 32'h0000_0002},
    '{1'b1, emu_run_pkg::CMD_OFF, 32'(emu_run_pkg::CMD_STOP)},
    '{1'b0, emu_run_pkg::STATUS_OFF, 32'h0000_0004}};
  emulator_run_control u_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .targetClockSeen(strapTgtClk), .internalClockSel(strapIntClk), .resetChar, .triggerHit,
    .counterReloadAction, .groupSwitchAction, .groupSwitchTarget, .countIncrementAction(1'b0),
    .breakAction, .cycleRequest, .targetReady, .cycleReady, .podReset, .targetReset, .eventsArmed,
    .countLimit, .irq);
  target_model u_tgt (.clk, .cycleRequest, .slowMode, .targetReady);
  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Verdict
  task automatic finish_test;
    $display("checked %0d nFail %0d", checked, nFail);
    if (nFail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer, then an idle clock
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      nFail++;
      finish_test();
    end
    @(posedge clk);
  endtask
  // One event clause with group switch
  task automatic evt(input logic rl, input logic bk, input logic [1:0] g);
    {triggerHit, groupSwitchAction} <= 2'h3;
    {counterReloadAction, breakAction, groupSwitchTarget} <= {rl, bk, g};
    @(posedge clk);
    {triggerHit, groupSwitchAction, counterReloadAction, breakAction} <= 4'h0;
    @(posedge clk);
  endtask
  // Pod cycle, counts clocks to its end
  task automatic cyc;
    cycleRequest <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cycleReady !== 1'b1 && n < 20);
    cycleRequest <= 1'b0;
    if (n >= 20) begin
      nFail++;
      finish_test();
    end
    repeat (2) @(posedge clk);
  endtask
  // Watchdog
  initial begin
    #2000000;
    nFail++;
    finish_test();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, slowMode, resetChar, triggerHit, breakAction} = '0;
    {counterReloadAction, groupSwitchAction, cycleRequest, paddr, pwdata, groupSwitchTarget} = '0;
    {strapTgtClk, strapIntClk} = 2'b10;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (ROWS[i]) begin
      apb(ROWS[i].wr, ROWS[i].adr, ROWS[i].dat);
      if (!ROWS[i].wr) chk(rd, ROWS[i].dat);
    end
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'b1, emu_run_pkg::CMP1_OFF, 32'h0000_0010);
    apb(1'b1, emu_run_pkg::IRQ_MASK_OFF, 32'h0000_0004);
    evt(1'b1, 1'b0, 2'h1);
    apb(1'b0, emu_run_pkg::CNT_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_0010);
    chk({31'h0, countLimit & irq}, 32'h0000_0001);
    evt(1'b0, 1'b0, 2'h2);
    apb(1'b0, emu_run_pkg::CNT_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_0010);
    apb(1'b1, emu_run_pkg::IRQ_STAT_OFF, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, emu_run_pkg::CMD_OFF, 32'(emu_run_pkg::CMD_RUN_BRK));
    evt(1'b0, 1'b1, 2'h2);
    apb(1'b0, emu_run_pkg::STATUS_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    apb(1'b0, emu_run_pkg::IRQ_STAT_OFF, 32'h0000_0000);
    chk({rd[30:0], irq}, 32'h0000_0006);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, emu_run_pkg::CTRL_OFF, 32'(k[1]));
      slowMode <= !k[0];
      cyc();
      chk(n, k[1] ? 2 : (k[0] ? 3 : 5));
    end
    apb(1'b1, emu_run_pkg::CS_OFF, 32'h0000_1234);
    apb(1'b1, emu_run_pkg::CMD_OFF, 32'(emu_run_pkg::CMD_RUN));
    resetChar <= 1'b1;
    @(posedge clk);
    resetChar <= 1'b0;
    repeat (6) @(posedge clk);
    apb(1'b0, emu_run_pkg::STATUS_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, emu_run_pkg::CS_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_1234);
    apb(1'b1, emu_run_pkg::CMD_OFF, 32'(emu_run_pkg::CMD_RUN));
    apb(1'b1, emu_run_pkg::CMD_OFF, 32'(emu_run_pkg::CMD_RESET));
    apb(1'b0, emu_run_pkg::CS_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_FFFF);
    // Second reset with no target clock and internal clock chosen
    {strapTgtClk, strapIntClk} <= 2'b01;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    apb(1'b0, emu_run_pkg::CTRL_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    finish_test();
  end
endmodule // emulator_run_control_bench
